// File: common/exs_pkg.sv
// Package for the exception state and type logic: numbers, vectors, priorities, carriers
package exs_pkg;

    // Exception numbering
    localparam int          NUM_EXC      = 48;          // Numbers 0..47
    localparam int          NUM_W        = 6;           // Width of an exception number
    localparam int          NUM_IRQ      = 32;          // Peripheral interrupts 0..31
    localparam logic [5:0]  EXC_RESET    = 6'h01;
    localparam logic [5:0]  EXC_NMI      = 6'h02;
    localparam logic [5:0]  EXC_FAULT    = 6'h03;
    localparam logic [5:0]  EXC_SVC      = 6'h0B;
    localparam logic [5:0]  EXC_DEFER    = 6'h0E;
    localparam logic [5:0]  EXC_TICK     = 6'h0F;
    localparam logic [5:0]  EXC_IRQ_BASE = 6'h10;       // Interrupt 0 maps here

    // Numbers that exist; 0, 4-10 and 12-13 are reserved
    localparam logic [47:0] EXC_IMPL     = 48'hFFFF_FFFF_C80E;

    // Vector offsets
    localparam logic [31:0] VEC_RESET    = 32'h0000_0004;
    localparam logic [31:0] VEC_NMI      = 32'h0000_0008;
    localparam logic [31:0] VEC_FAULT    = 32'h0000_000C;
    localparam logic [31:0] VEC_SVC      = 32'h0000_002C;
    localparam logic [31:0] VEC_DEFER    = 32'h0000_0038;
    localparam logic [31:0] VEC_TICK     = 32'h0000_003C;
    localparam logic [31:0] VEC_IRQ_BASE = 32'h0000_0040;
    localparam logic [31:0] VEC_STEP     = 32'h0000_0004; // Each interrupt one word up

    // Urgency ranks: lower is more urgent; 0..2 are the fixed -3, -2, -1
    localparam logic [2:0]  RANK_RESET   = 3'h0;
    localparam logic [2:0]  RANK_NMI     = 3'h1;
    localparam logic [2:0]  RANK_FAULT   = 3'h2;
    localparam logic [2:0]  RANK_CFG0    = 3'h3;        // Configurable 0; +1 per step of 64
    localparam logic [2:0]  RANK_THREAD  = 3'h7;        // Nothing active
    localparam logic [1:0]  PRIO_RESET   = 2'h0;        // Configurable level after reset

    // Reset values
    localparam logic [47:0] PEND_RESET   = 48'h0;
    localparam logic [47:0] ACT_RESET    = 48'h0;

    // Per-source software configuration
    typedef struct packed {
        logic [47:0]      enable;       // Enable of configurable sources
        logic [47:0][1:0] level;        // Level 0..3 meaning 0, 64, 128, 192
        logic             mask_cfg;     // Blocks every configurable source
    } exs_cfg_t;

    // Entry descriptor offered to the core
    typedef struct packed {
        logic [5:0]  num;               // Exception number
        logic [31:0] vector;            // Vector offset
        logic        sync;              // Synchronous activation
    } exs_entry_t;

    // Sequencer state after reset
    typedef enum logic [1:0] {
        ST_HALT    = 2'b00,
        ST_RESTART = 2'b01,
        ST_RUN     = 2'b10
    } exs_state_t;

endpackage

// File: design/exs_core.sv
// Exception state tracking, type table, prioritisation and handler entry/return
`timescale 1ns/1ps
`default_nettype none

module exs_core (
    input  wire logic                CLK,              // 200 MHz core clock
    input  wire logic                SYS_RST,          // Asynchronous, active high
    input  wire logic [31:0]         IRQ_LINES,        // Peripheral lines, rising edge requests
    input  wire logic                NMI_LINE,         // Peripheral non-maskable line, rising edge
    input  wire logic                FAULT_REQ,        // Error during exception processing
    input  wire logic                SVC_EXEC,         // Supervisor-call instruction executed
    input  wire logic                TICK_ZERO,        // System timer reached zero
    input  wire logic [47:0]         SW_SET_PEND,      // Software pend requests, one bit per number
    input  wire exs_pkg::exs_cfg_t   CFG,              // Enables, levels, mask
    input  wire logic                ENTRY_READY,      // Core takes the offered entry
    input  wire logic                RETURN_STB,       // Handler completed
    input  wire logic [5:0]          RETURN_NUM,       // Number of the completed handler
    output logic                     CORE_HALT,        // Core stopped while reset held
    output logic                     RESTART_STB,      // One pulse after reset release
    output logic [31:0]              RESTART_VECTOR,   // Reset vector offset
    output logic                     ENTRY_VALID,      // Entry offered
    output exs_pkg::exs_entry_t      ENTRY,            // Offered entry
    output logic [47:0]              PENDING,          // Pending flags
    output logic [47:0]              ACTIVE,           // Active flags
    output logic                     THREAD_MODE,      // No handler active
    output logic [5:0]               INT_PROG_STATUS   // Number of running handler, 0 in thread
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Urgency rank of a number from its fixed or configured priority
    function automatic logic [2:0] rank_of(input logic [5:0] n, input exs_pkg::exs_cfg_t c);
        logic [2:0] r;
        r = 3'h0;
        case (n)
            exs_pkg::EXC_RESET: r = exs_pkg::RANK_RESET;
            exs_pkg::EXC_NMI:   r = exs_pkg::RANK_NMI;
            exs_pkg::EXC_FAULT: r = exs_pkg::RANK_FAULT;
            default:            r = exs_pkg::RANK_CFG0 + {1'b0, c.level[n]};
        endcase
        return r;
    endfunction

    // Fixed priority sources are never disabled or masked
    function automatic logic is_fixed(input logic [5:0] n);
        return (n == exs_pkg::EXC_RESET) || (n == exs_pkg::EXC_NMI) || (n == exs_pkg::EXC_FAULT);
    endfunction

    // Vector offset of a number
    function automatic logic [31:0] vector_of(input logic [5:0] n);
        logic [31:0] v;
        v = 32'h0;
        case (n)
            exs_pkg::EXC_RESET: v = exs_pkg::VEC_RESET;
            exs_pkg::EXC_NMI:   v = exs_pkg::VEC_NMI;
            exs_pkg::EXC_FAULT: v = exs_pkg::VEC_FAULT;
            exs_pkg::EXC_SVC:   v = exs_pkg::VEC_SVC;
            exs_pkg::EXC_DEFER: v = exs_pkg::VEC_DEFER;
            exs_pkg::EXC_TICK:  v = exs_pkg::VEC_TICK;
            default:            v = exs_pkg::VEC_IRQ_BASE
                                    + exs_pkg::VEC_STEP * {26'h0, n - exs_pkg::EXC_IRQ_BASE};
        endcase
        return v;
    endfunction

    // Synchronous activation only for fault and supervisor call
    function automatic logic is_sync(input logic [5:0] n);
        return (n == exs_pkg::EXC_FAULT) || (n == exs_pkg::EXC_SVC);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    exs_pkg::exs_state_t   st_q,       st_d;       // Reset sequencer
    logic [47:0]           pend_q,     pend_d;     // Pending flag per number
    logic [47:0]           act_q,      act_d;      // Active flag per number
    logic [31:0]           irq_prev_q, irq_prev_d; // Previous line levels
    logic                  nmi_prev_q, nmi_prev_d; // Previous NMI level
    logic                  vld_q,      vld_d;      // Entry offered
    exs_pkg::exs_entry_t   ent_q,      ent_d;      // Offered entry
    logic [5:0]            ips_q,      ips_d;      // Running handler number
    logic                  rst_stb_q,  rst_stb_d;  // Restart pulse

    logic [47:0]           req;                    // Request strobes this cycle
    logic                  take;                   // Core accepted the entry
    logic [2:0]            cur_rank;               // Rank of execution
    logic [5:0]            cur_num;                // Most urgent active number
    logic [2:0]            best_rank;              // Best eligible pending rank
    logic [5:0]            best_num;               // Its number
    logic                  best_vld;               // Any eligible pending

    ////////////////////////////////////////////////////////////////////////////
    // Request gathering

    // Edges and strobes from every source; reserved numbers never request
    always_comb begin
        req = SW_SET_PEND;
        req[exs_pkg::NUM_IRQ + 15:16] = SW_SET_PEND[47:16] | (IRQ_LINES & ~irq_prev_q);
        req[exs_pkg::EXC_NMI]   = SW_SET_PEND[exs_pkg::EXC_NMI] | (NMI_LINE & ~nmi_prev_q);
        req[exs_pkg::EXC_FAULT] = FAULT_REQ;
        req[exs_pkg::EXC_SVC]   = SVC_EXEC;
        req[exs_pkg::EXC_DEFER] = SW_SET_PEND[exs_pkg::EXC_DEFER];
        req[exs_pkg::EXC_TICK]  = TICK_ZERO | SW_SET_PEND[exs_pkg::EXC_TICK];
        req[exs_pkg::EXC_RESET] = 1'b0;                             // Reset is the pin, not a flag
        req = req & exs_pkg::EXC_IMPL;
        if (st_q != exs_pkg::ST_RUN) begin
            req = 48'h0;                                            // Core halted, nothing counts
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Current execution priority

    // Most urgent active handler; nested ones all stay active
    always_comb begin
        cur_rank = exs_pkg::RANK_THREAD;
        cur_num  = 6'h00;
        for (int i = exs_pkg::NUM_EXC - 1; i >= 0; i--) begin
            if (act_q[i] && (rank_of(6'(i), CFG) <= cur_rank)) begin
                cur_rank = rank_of(6'(i), CFG);
                cur_num  = 6'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Selection of the next entry

    // Scan downwards with <= so the lowest number wins a tie
    always_comb begin
        best_rank = exs_pkg::RANK_THREAD;
        best_num  = 6'h00;
        best_vld  = 1'b0;
        for (int i = exs_pkg::NUM_EXC - 1; i >= 0; i--) begin
            if (pend_q[i] && !act_q[i]
                && (is_fixed(6'(i)) || (CFG.enable[i] && !CFG.mask_cfg))
                && (rank_of(6'(i), CFG) <= best_rank)) begin
                best_rank = rank_of(6'(i), CFG);
                best_num  = 6'(i);
                best_vld  = 1'b1;
            end
        end
        // Equal rank never preempts; it simply stays pending
        if (best_rank >= cur_rank) begin
            best_vld = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the flags and the offer

    // Take only a registered offer, then withdraw it for one cycle to re-evaluate
    assign take = vld_q && ENTRY_READY;

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer

    // One halted edge after release, then a single restart pulse, then run
    always_comb begin
        st_d      = st_q;
        rst_stb_d = 1'b0;
        case (st_q)
            exs_pkg::ST_HALT: begin
                st_d = exs_pkg::ST_RESTART;                         // First edge after release
            end
            exs_pkg::ST_RESTART: begin
                rst_stb_d = 1'b1;
                st_d      = exs_pkg::ST_RUN;
            end
            exs_pkg::ST_RUN: begin
                st_d = exs_pkg::ST_RUN;                             // Left only through the reset pin
            end
            default: begin
                st_d = exs_pkg::ST_HALT;                            // Stray code restarts the sequence
            end
        endcase
    end

    // Only the asynchronous pin sends the sequencer back to halt
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q      <= exs_pkg::ST_HALT;
            rst_stb_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            rst_stb_q <= rst_stb_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending and active flags

    // Flags move only while running; a halted core records nothing
    always_comb begin
        pend_d = pend_q;
        act_d  = act_q;
        if (st_q == exs_pkg::ST_RUN) begin
            // Completion clears active; a recorded request stays pending
            if (RETURN_STB) begin
                act_d[RETURN_NUM] = 1'b0;
            end
            // Entry moves the source from pending to active
            if (take) begin
                pend_d[ent_q.num] = 1'b0;
                act_d[ent_q.num]  = 1'b1;
            end
            // New requests win over the clear of the same cycle
            pend_d = pend_d | req;
        end
    end

    // Reset empties every flag, so all sources start inactive
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pend_q <= exs_pkg::PEND_RESET;
            act_q  <= exs_pkg::ACT_RESET;
        end else begin
            pend_q <= pend_d;
            act_q  <= act_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line history for edge detection

    // Levels of this cycle become the reference for the next
    always_comb begin
        irq_prev_d = IRQ_LINES;
        nmi_prev_d = NMI_LINE;
    end

    // Cleared to the idle low level, so no false edge follows reset
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            irq_prev_q <= 32'h0;
            nmi_prev_q <= 1'b0;
        end else begin
            irq_prev_q <= irq_prev_d;
            nmi_prev_q <= nmi_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Entry offer and running handler number

    // Offer rebuilt every cycle; a take or a return silences it for one cycle
    always_comb begin
        vld_d        = best_vld && !take && !RETURN_STB && (st_q == exs_pkg::ST_RUN);
        ent_d.num    = best_num;
        ent_d.vector = vector_of(best_num);
        ent_d.sync   = is_sync(best_num);
        ips_d        = cur_num;
        // The entered handler is the one running from the next cycle
        if (take) begin
            ips_d = ent_q.num;
        end
    end

    // Registered so the core sees a steady number, vector and kind
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            vld_q <= 1'b0;
            ent_q <= '0;
            ips_q <= 6'h00;
        end else begin
            vld_q <= vld_d;
            ent_q <= ent_d;
            ips_q <= ips_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Halt follows the pin at once, so even a half-done instruction stops
    assign CORE_HALT       = SYS_RST || (st_q != exs_pkg::ST_RUN);
    assign RESTART_STB     = rst_stb_q;
    assign RESTART_VECTOR  = exs_pkg::VEC_RESET;
    assign ENTRY_VALID     = vld_q;
    assign ENTRY           = ent_q;
    assign PENDING         = pend_q;
    assign ACTIVE          = act_q;
    assign THREAD_MODE     = (act_q == 48'h0);
    assign INT_PROG_STATUS = ips_q;

endmodule

`default_nettype wire

// File: verif/exception_state_and_type_logic_tb.sv
// Self-checking bench for the exception state and type logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module exception_state_and_type_logic_tb;
    logic                clk = 1'b0;                   // 200 MHz clock
    logic                sys_rst = 1'b1;               // Held 20 cycles
    logic [31:0]         irq_lines = 32'h0;            // Peripheral lines
    logic                nmi_line = 1'b0, fault_req = 1'b0, svc_exec = 1'b0, tick_zero = 1'b0;
    logic [47:0]         sw_set_pend = 48'h0;          // Software pends
    exs_pkg::exs_cfg_t   cfg = '{enable: 48'hFFFF_FFFF_FFFF, level: 96'h0, mask_cfg: 1'b0};
    logic                ret_stb = 1'b0, go = 1'b0, slow = 1'b0, entry_ready;
    logic [5:0]          ret_num = 6'h0, ips, n;
    logic                core_halt, restart_stb, entry_valid, thread_mode;
    logic [31:0]         restart_vector, seed = 32'hE644;
    exs_pkg::exs_entry_t entry;
    logic [47:0]         pending, active;
    int                  errors = 0, comparisons = 0, cyc = 0;
    exs_core exs_core_i (.CLK(clk), .SYS_RST(sys_rst), .IRQ_LINES(irq_lines), .NMI_LINE(nmi_line),
        .FAULT_REQ(fault_req), .SVC_EXEC(svc_exec), .TICK_ZERO(tick_zero), .SW_SET_PEND(sw_set_pend),
        .CFG(cfg), .ENTRY_READY(entry_ready), .RETURN_STB(ret_stb), .RETURN_NUM(ret_num),
        .CORE_HALT(core_halt), .RESTART_STB(restart_stb), .RESTART_VECTOR(restart_vector),
        .ENTRY_VALID(entry_valid), .ENTRY(entry), .PENDING(pending), .ACTIVE(active),
        .THREAD_MODE(thread_mode), .INT_PROG_STATUS(ips));
    exs_seq_model exs_seq_model_i (.clk(clk), .sys_rst(sys_rst), .go(go), .slow(slow), .entry_ready(entry_ready));
    ////////////////////////////////////////////////////////////////////////////
    always #2.5 clk = ~clk;
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Expected vector offset of an exception number
    function automatic logic [31:0] exp_vec(input logic [5:0] k);
        case (k)
            6'h02: return 32'h0000_0008;
            6'h03: return 32'h0000_000C;
            6'h0B: return 32'h0000_002C;
            6'h0E: return 32'h0000_0038;
            6'h0F: return 32'h0000_003C;
            default: return 32'h0000_0040 + 32'h0000_0004 * (k - 6'h10);
        endcase
    endfunction
    // Inputs always move 1 ns after the edge
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic pend(input logic [47:0] b);
        sw_set_pend = b;
        step(1);
        sw_set_pend = 48'h0;
        step(1);
    endtask
    // Wait for an offer with the sequencer holding off, then check it
    task automatic offer(input logic [5:0] k);
        int w;
        w = 0;
        while (entry_valid !== 1'b1 && w < 50) begin
            step(1);
            w++;
        end
        `CHK(entry_valid, 1'b1)
        `CHK(entry.num, k)
        `CHK(entry.vector, exp_vec(k))
        `CHK(entry.sync, (k == 6'h03 || k == 6'h0B))
    endtask
    task automatic take(input logic [5:0] k);
        int w;
        w = 0;
        go = 1'b1;
        while (active[k] !== 1'b1 && w < 50) begin
            step(1);
            w++;
        end
        go = 1'b0;
        `CHK(active[k], 1'b1)
        `CHK(ips, k)
        `CHK(pending[k], 1'b0)
    endtask
    // Gap cycle after the strobe so back-to-back returns never collide
    task automatic ret(input logic [5:0] k);
        ret_stb = 1'b1;
        ret_num = k;
        step(1);
        ret_stb = 1'b0;
        `CHK(active[k], 1'b0)
        step(1);
    endtask
    task automatic serve(input logic [5:0] k);
        offer(k);
        take(k);
        ret(k);
    endtask
    task automatic report_and_stop();
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        step(20);
        sys_rst = 1'b0;
        `CHK(core_halt, 1'b1)
        step(2);
        `CHK(restart_stb, 1'b1)
        `CHK(restart_vector, 32'h0000_0004)
        step(1);
        `CHK(core_halt, 1'b0)
        // Fault, then an NMI nests above it while a masked call waits
        fault_req = 1'b1;
        step(1);
        fault_req = 1'b0;
        serve(6'h03);
        pend(48'h0); // settle
        fault_req = 1'b1;
        step(1);
        fault_req = 1'b0;
        offer(6'h03);
        take(6'h03);
        svc_exec = 1'b1;
        cfg.mask_cfg = 1'b1;
        step(1);
        svc_exec = 1'b0;
        nmi_line = 1'b1;
        offer(6'h02);
        take(6'h02);
        `CHK(active[3], 1'b1)
        ret(6'h02);
        ret(6'h03);
        step(4);
        `CHK(entry_valid, 1'b0)
        `CHK(pending[11], 1'b1)
        cfg.mask_cfg = 1'b0;
        nmi_line = 1'b0;
        serve(6'h0B);
        // Level beats number; then a tie and an equal-level arrival
        cfg.level[17] = 2'h3;
        pend((48'h1 << 17) | (48'h1 << 20));
        serve(6'h14);
        serve(6'h11);
        pend((48'h1 << 18) | (48'h1 << 21));
        offer(6'h12);
        take(6'h12);
        step(4);
        `CHK(entry_valid, 1'b0)
        pend(48'h1 << 18);
        `CHK(pending[18] & active[18], 1'b1)
        ret(6'h12);
        `CHK(pending[18], 1'b1)
        serve(6'h12);
        serve(6'h15);
        // Disabled source waits pending
        cfg.enable[19] = 1'b0;
        pend(48'h1 << 19);
        step(3);
        `CHK(pending[19] & ~entry_valid, 1'b1)
        cfg.enable[19] = 1'b1;
        serve(6'h13);
        // Timer and deferred request together: lower number first
        tick_zero = 1'b1;
        sw_set_pend = 48'h1 << 14;
        step(1);
        tick_zero = 1'b0;
        sw_set_pend = 48'h0;
        serve(6'h0E);
        serve(6'h0F);
        // Random peripheral lines, levels and sequencer stalls
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            n = 6'h10 + {1'b0, seed[4:0]};
            cfg.level[n] = seed[9:8];
            slow = seed[12];
            irq_lines[seed[4:0]] = 1'b1;
            step(1);
            irq_lines = 32'h0;
            serve(n);
        end
        `CHK(thread_mode, 1'b1)
        report_and_stop();
    end
endmodule
`default_nettype wire

// File: verif/exs_core_props.sv
// Port checker for the exception state and type logic, bound to its top
`timescale 1ns/1ps
`default_nettype none
module exs_core_props (
    input wire logic                CLK,
    input wire logic                SYS_RST,
    input wire logic                NMI_LINE,
    input wire logic                FAULT_REQ,
    input wire logic                ENTRY_READY,
    input wire logic                RETURN_STB,
    input wire logic [5:0]          RETURN_NUM,
    input wire logic                CORE_HALT,
    input wire logic                RESTART_STB,
    input wire logic [31:0]         RESTART_VECTOR,
    input wire logic                ENTRY_VALID,
    input wire exs_pkg::exs_entry_t ENTRY,
    input wire logic [47:0]         PENDING,
    input wire logic [47:0]         ACTIVE,
    input wire logic [5:0]          INT_PROG_STATUS
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////////////////
    // Halt must hold during reset itself, so no disable here
    halt_in_reset_a: assert property (disable iff (1'b0) SYS_RST |-> CORE_HALT)
        else $error("core not halted in reset");
    restart_seq_a: assert property ($fell(SYS_RST) |-> CORE_HALT ##1 CORE_HALT
        ##1 (RESTART_STB && !CORE_HALT && RESTART_VECTOR == 32'h0000_0004) ##1 !RESTART_STB)
        else $error("bad restart sequence");
    irq_vector_a: assert property (ENTRY_VALID && ENTRY.num >= 6'h10 |->
        ENTRY.vector == 32'h0000_0040 + {24'h0, ENTRY.num - 6'h10, 2'h0}) else $error("bad vector");
    sync_kind_a: assert property (ENTRY_VALID |-> ENTRY.sync == (ENTRY.num == 6'h03 || ENTRY.num == 6'h0B))
        else $error("bad sync flag");
    take_activates_a: assert property (ENTRY_VALID && ENTRY_READY |=> !ENTRY_VALID &&
        ACTIVE[$past(ENTRY.num)] && INT_PROG_STATUS == $past(ENTRY.num)) else $error("take lost");
    reserved_clear_a: assert property (((PENDING | ACTIVE) & ~exs_pkg::EXC_IMPL) == 48'h0)
        else $error("reserved flag set");
    return_clears_a: assert property (RETURN_STB |=> !ACTIVE[$past(RETURN_NUM)])
        else $error("active kept after return");
    offer_legal_a: assert property (ENTRY_VALID |-> PENDING[ENTRY.num] && !ACTIVE[ENTRY.num])
        else $error("offer of non pending source");
    fault_pends_a: assert property (FAULT_REQ && !CORE_HALT |=> PENDING[3])
        else $error("fault not pended");
    nmi_pends_a: assert property ($rose(NMI_LINE) && !CORE_HALT |=> PENDING[2])
        else $error("nmi not pended");
    // Main scenarios reached
    cover property (ACTIVE[2] && ACTIVE[3]);
    cover property (ENTRY_VALID && ENTRY_READY && ENTRY.sync);
    cover property ((PENDING & ACTIVE) != 48'h0);
endmodule
bind exs_core exs_core_props exs_core_props_i (.CLK(CLK), .SYS_RST(SYS_RST), .NMI_LINE(NMI_LINE),
    .FAULT_REQ(FAULT_REQ), .ENTRY_READY(ENTRY_READY), .RETURN_STB(RETURN_STB), .RETURN_NUM(RETURN_NUM),
    .CORE_HALT(CORE_HALT), .RESTART_STB(RESTART_STB), .RESTART_VECTOR(RESTART_VECTOR),
    .ENTRY_VALID(ENTRY_VALID), .ENTRY(ENTRY), .PENDING(PENDING), .ACTIVE(ACTIVE),
    .INT_PROG_STATUS(INT_PROG_STATUS));
`default_nettype wire

// File: verif/exs_seq_model.sv
// Handler-entry sequencer model that takes offers promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module exs_seq_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire logic slow,
    output var logic entry_ready
);
    logic [1:0] cnt_q; // Stall pattern phase
    // Registered so ready only moves just after an edge; slow takes one cycle in four
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q       <= 2'h0;
            entry_ready <= 1'b0;
        end else begin
            cnt_q       <= cnt_q + 2'h1;
            entry_ready <= go && (!slow || cnt_q == 2'h3);
        end
    end
endmodule
`default_nettype wire
